//--- core/cfgh_host.sv
// Passive serial configuration host: resets the device, streams a bitstream, awaits done.
//
// Summary of operation
// - JTAG host waits 32 us after reset.
// - JTAG clock at most 10 or 3 MHz.
// - External active clock at most 100 MHz.
// - Single-bit data, SPI mode 3 timing.
// - Stop clock whenever no valid data.
// - Resume with next bit, none skipped.
// - Hold configuration select high throughout load.
// - Hold slave select low throughout load.
// - Give at least 100 clocks after data.
// - Configuration clock at most 100 MHz.
// - First data 32 us after reset release.
// - Prefer one slave on the bus.
// - Pulse reset low at least 0.32 us.
// - Hold interface in reset 25 us after done.
`timescale 1ns/1ps
`default_nettype none
`include "cfgh_map.svh"
module cfgh_host
	import cfgh_pkg::*;
#(
	parameter int CLK_DIV = `CFGH_CLK_DIV_DEF,
	parameter int FIRST_DATA_CYC = `CFGH_FIRST_DATA_CYC,
	parameter int USER_HOLD_CYC = `CFGH_USER_HOLD_CYC,
	parameter int DONE_TIMEOUT = `CFGH_DONE_TIMEOUT_DEF
) (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// Command port.
	input wire logic i_start,
	input wire logic i_last,
	output logic o_busy,
	output logic o_done,
	output logic o_error,
	output logic o_user_reset_n,
	// Bitstream byte stream, most significant bit first.
	input wire logic i_byte_valid,
	input wire logic [`CFGH_BIT_MSB:0] i_byte_data,
	output logic o_byte_ready,
	// Device pins.
	output logic o_config_serial_clock,
	output logic o_config_serial_data_in,
	output logic o_flash_slave_select_n,
	output logic o_config_select,
	output logic o_config_reset_n,
	input wire logic i_config_complete_flag
);
	localparam int RST_CYC = `CFGH_RESET_LOW_CYC;
	localparam int HALF = (CLK_DIV / 2 < 1) ? 1 : CLK_DIV / 2;
	localparam int CW = 32;

	//////////////////////////////////////////////////////////////////////////////
	// Byte buffer; its ready is the block's own byte ready toward the source.
	logic fifo_valid, fifo_take;
	logic [`CFGH_BIT_MSB:0] fifo_data;
	cfgh_fifo #(.WIDTH(`CFGH_BIT_MSB + 1), .DEPTH(`CFGH_FIFO_DEPTH)) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_in_valid(i_byte_valid),
		.i_in_data(i_byte_data),
		.o_in_ready(o_byte_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(fifo_take)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Done input crosses in from an open-drain pin: three flops, second and third agree.
	logic [2:0] done_sync_reg;
	logic done_level_reg, done_level_next;
	always_comb begin
		done_level_next = done_level_reg;
		if (done_sync_reg[1] == done_sync_reg[2]) begin
			done_level_next = done_sync_reg[2];
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			done_sync_reg <= 3'h0;
			done_level_reg <= 1'b0;
		end else begin
			done_sync_reg <= {done_sync_reg[1:0], i_config_complete_flag};
			done_level_reg <= done_level_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Sequencer and serialiser state.
	cfgh_state_t state_reg, state_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic [7:0] div_reg, div_next;
	logic [`CFGH_BIT_MSB:0] sh_reg, sh_next;
	logic [3:0] bits_reg, bits_next;
	logic last_reg, last_next;
	logic sclk_reg, sclk_next;
	logic sdat_reg, sdat_next;
	logic ssel_n_reg, ssel_n_next;
	logic csel_reg, csel_next;
	logic crst_n_reg, crst_n_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic err_reg, err_next;
	logic urst_n_reg, urst_n_next;
	logic half_tick;

	// The clock is built by division of the system clock; mode 3 idles it high.
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		div_next = div_reg;
		sh_next = sh_reg;
		bits_next = bits_reg;
		last_next = last_reg;
		sclk_next = sclk_reg;
		sdat_next = sdat_reg;
		ssel_n_next = ssel_n_reg;
		csel_next = csel_reg;
		crst_n_next = crst_n_reg;
		busy_next = busy_reg;
		done_next = done_reg;
		err_next = err_reg;
		urst_n_next = urst_n_reg;
		fifo_take = 1'b0;
		half_tick = (div_reg == 8'(HALF - 1));
		unique case (state_reg)
			CFGH_IDLE: begin
				sclk_next = 1'b1;
				if (i_start) begin
					state_next = CFGH_RESET;
					cnt_next = '0;
					busy_next = 1'b1;
					done_next = 1'b0;
					err_next = 1'b0;
					urst_n_next = 1'b0;
					crst_n_next = 1'b0;
					ssel_n_next = 1'b0;
					csel_next = 1'b1;
					bits_next = 4'h0;
					last_next = 1'b0;
				end
			end
			CFGH_RESET: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CW'(RST_CYC - 1)) begin
					crst_n_next = 1'b1;
					cnt_next = '0;
					state_next = CFGH_WAIT;
				end
			end
			CFGH_WAIT: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg >= CW'(FIRST_DATA_CYC - 1)) begin
					state_next = CFGH_SHIFT;
					div_next = 8'h0;
				end
			end
			CFGH_SHIFT: begin
				// With no bits left the clock is parked high until a byte arrives.
				if (bits_reg == 4'h0) begin
					if (sclk_reg && fifo_valid) begin
						fifo_take = 1'b1;
						sh_next = {fifo_data[`CFGH_BIT_MSB-1:0], 1'b0};
						sdat_next = fifo_data[`CFGH_BIT_MSB];
						bits_next = 4'(`CFGH_BIT_MSB + 1);
						div_next = 8'h0;
					end else if (sclk_reg && last_reg) begin
						state_next = CFGH_TAIL;
						cnt_next = '0;
						div_next = 8'h0;
					end
				end else begin
					div_next = half_tick ? 8'h0 : 8'(div_reg + 1'b1);
					if (half_tick) begin
						sclk_next = !sclk_reg;
						if (!sclk_reg) begin
							// Rising edge just delivered one bit; advance on the fall.
							bits_next = 4'(bits_reg - 1'b1);
						end else if (bits_reg != 4'(`CFGH_BIT_MSB + 1) || 1'b1) begin
							sdat_next = (bits_reg == 4'(`CFGH_BIT_MSB + 1)) ? sdat_reg : sh_reg[`CFGH_BIT_MSB];
							if (bits_reg != 4'(`CFGH_BIT_MSB + 1)) begin
								sh_next = {sh_reg[`CFGH_BIT_MSB-1:0], 1'b0};
							end
						end
					end
				end
				if (i_last) begin
					last_next = 1'b1;
				end
			end
			CFGH_TAIL: begin
				div_next = half_tick ? 8'h0 : 8'(div_reg + 1'b1);
				if (half_tick) begin
					sclk_next = !sclk_reg;
					if (!sclk_reg) begin
						cnt_next = cnt_reg + 1'b1;
						if (cnt_reg == CW'(`CFGH_TAIL_CLOCKS - 1)) begin
							state_next = CFGH_DONE_WAIT;
							cnt_next = '0;
						end
					end
				end
			end
			CFGH_DONE_WAIT: begin
				sclk_next = 1'b1;
				cnt_next = cnt_reg + 1'b1;
				if (done_level_reg) begin
					state_next = CFGH_USER_HOLD;
					cnt_next = '0;
				end else if (cnt_reg == CW'(DONE_TIMEOUT - 1)) begin
					err_next = 1'b1;
					state_next = CFGH_FINISH;
				end
			end
			CFGH_USER_HOLD: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CW'(USER_HOLD_CYC - 1)) begin
					urst_n_next = 1'b1;
					done_next = 1'b1;
					state_next = CFGH_FINISH;
				end
			end
			CFGH_FINISH: begin
				busy_next = 1'b0;
				ssel_n_next = 1'b1;
				csel_next = 1'b0;
				state_next = CFGH_IDLE;
			end
			default: begin
				state_next = CFGH_IDLE;
			end
		endcase
	end

	// Registers only; every pin output comes straight from one of these.
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			state_reg <= CFGH_IDLE;
			cnt_reg <= '0;
			div_reg <= 8'h0;
			sh_reg <= 8'h0;
			bits_reg <= 4'h0;
			last_reg <= 1'b0;
			sclk_reg <= 1'b1;
			sdat_reg <= 1'b1;
			ssel_n_reg <= 1'b1;
			csel_reg <= 1'b0;
			crst_n_reg <= 1'b1;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			urst_n_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			div_reg <= div_next;
			sh_reg <= sh_next;
			bits_reg <= bits_next;
			last_reg <= last_next;
			sclk_reg <= sclk_next;
			sdat_reg <= sdat_next;
			ssel_n_reg <= ssel_n_next;
			csel_reg <= csel_next;
			crst_n_reg <= crst_n_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			err_reg <= err_next;
			urst_n_reg <= urst_n_next;
		end
	end

	assign o_config_serial_clock = sclk_reg;
	assign o_config_serial_data_in = sdat_reg;
	assign o_flash_slave_select_n = ssel_n_reg;
	assign o_config_select = csel_reg;
	assign o_config_reset_n = crst_n_reg;
	assign o_busy = busy_reg;
	assign o_done = done_reg;
	assign o_error = err_reg;
	assign o_user_reset_n = urst_n_reg;

	//////////////////////////////////////////////////////////////////////////////
	// Checks on the pins this host drives.
	property p_sel_held;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(state_reg == CFGH_SHIFT || state_reg == CFGH_TAIL) |-> (csel_reg && !ssel_n_reg);
	endproperty
	a_sel_held: assert property (p_sel_held) else $error("Selects not held during load.");

	property p_ssel_low;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(state_reg == CFGH_WAIT) |-> !ssel_n_reg;
	endproperty
	a_ssel_low: assert property (p_ssel_low) else $error("Slave select high in load.");

	property p_reset_pulse;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		$fell(crst_n_reg) |-> !crst_n_reg [*8] ##1 !crst_n_reg [*8] ##1 !crst_n_reg [*8] ##1 !crst_n_reg [*8];
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("Reset pulse too short.");

	property p_no_early_clock;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(state_reg == CFGH_WAIT) |-> sclk_reg;
	endproperty
	a_no_early_clock: assert property (p_no_early_clock) else $error("Clock before wait ended.");

	property p_clock_parks;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(state_reg == CFGH_SHIFT && bits_reg == 4'h0 && sclk_reg) |=> sclk_reg;
	endproperty
	a_clock_parks: assert property (p_clock_parks) else $error("Clock ran without data.");

	property p_clock_rate;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		$changed(sclk_reg) |-> ($past(div_reg) == 8'(HALF - 1));
	endproperty
	a_clock_rate: assert property (p_clock_rate) else $error("Clock faster than allowed.");

	property p_tail;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		(state_reg == CFGH_TAIL) |-> (cnt_reg <= CW'(`CFGH_TAIL_CLOCKS));
	endproperty
	a_tail: assert property (p_tail) else $error("Tail count out of range.");

	property p_user_hold;
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		$rose(urst_n_reg) |-> $past(state_reg) == CFGH_USER_HOLD;
	endproperty
	a_user_hold: assert property (p_user_hold) else $error("User reset released early.");
endmodule
`default_nettype wire

//--- core/cfgh_map.svh
// Constants for the passive serial configuration host: timing counts, defaults and sizes.
`ifndef CFGH_MAP_SVH
`define CFGH_MAP_SVH
`define CFGH_SYS_MHZ 100
`define CFGH_RESET_LOW_NS 320
`define CFGH_RESET_LOW_CYC ((`CFGH_RESET_LOW_NS * `CFGH_SYS_MHZ + 999) / 1000)
`define CFGH_FIRST_DATA_US 32
`define CFGH_FIRST_DATA_CYC (`CFGH_FIRST_DATA_US * `CFGH_SYS_MHZ)
`define CFGH_USER_HOLD_US 25
`define CFGH_USER_HOLD_CYC (`CFGH_USER_HOLD_US * `CFGH_SYS_MHZ)
`define CFGH_TAIL_CLOCKS 100
`define CFGH_CLK_DIV_DEF 4
`define CFGH_DONE_TIMEOUT_DEF 100000
`define CFGH_FIFO_DEPTH 16
`define CFGH_BIT_MSB 7
`endif

//--- core/cfgh_pkg.sv
// Types shared by the passive serial configuration host.
package cfgh_pkg;
	typedef enum logic [2:0] {
		CFGH_IDLE = 3'b000,
		CFGH_RESET = 3'b001,
		CFGH_WAIT = 3'b011,
		CFGH_SHIFT = 3'b010,
		CFGH_TAIL = 3'b110,
		CFGH_DONE_WAIT = 3'b111,
		CFGH_USER_HOLD = 3'b101,
		CFGH_FINISH = 3'b100
	} cfgh_state_t;
	typedef struct packed {
		logic clk;
		logic data;
		logic ssel_n;
		logic csel;
		logic creset_n;
	} cfgh_pins_t;
	typedef struct packed {
		logic busy;
		logic done;
		logic error;
	} cfgh_stat_t;
endpackage

//--- core/cfgh_fifo.sv
// Parameterised valid/ready FIFO feeding bitstream bytes to the serialiser.
`timescale 1ns/1ps
`default_nettype none
module cfgh_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// Fill side.
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// Drain side.
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;
	logic ready_reg, ready_next;

	// Pointers advance only on accepted handshakes, so full and empty stay honest.
	always_comb begin
		push = i_in_valid && ready_reg;
		pop = (cnt_reg != '0) && i_out_ready;
		wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 1'b1;
		end
		// Ready is registered from the next count, so it leaves a flip-flop yet tracks full exactly.
		ready_next = (cnt_next != (AW+1)'(DEPTH));
	end

	// Storage has no reset; only the pointers, count and ready flag need a defined value.
	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem[wr_reg] <= i_in_data;
		end
		if (!i_reset_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			ready_reg <= 1'b1;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			ready_reg <= ready_next;
		end
	end

	assign o_in_ready = ready_reg;
	assign o_out_valid = (cnt_reg != '0);
	assign o_out_data = mem[rd_reg];
endmodule
`default_nettype wire

//--- test/cfgh_dev_model.sv
// Behavioural passive serial configuration target with an open-drain done pin.
`timescale 1ns/1ps
`default_nettype none
module cfgh_dev_model #(
	parameter int FIRST_NS = 200
) (
	// Pins from the host.
	// The serial clock is only an input: the passive load alone is modelled,
	// so the target's own divided clock toward a flash is absent.
	input wire logic i_config_serial_clock,
	input wire logic i_config_serial_data_in,
	input wire logic i_ssel_n,
	input wire logic i_csel,
	input wire logic i_creset_n,
	// Bench controls.
	input wire logic [15:0] i_expect_bytes,
	input wire logic i_hold_done,
	// Done pin and counters.
	output logic o_done_pin,
	output logic [15:0] o_bits,
	output logic [15:0] o_tail,
	output logic [7:0] o_viol
);
	logic [7:0] mem [0:31];
	logic [7:0] sh;
	logic pull_low;
	realtime t_fall;
	realtime t_rel;
	realtime t_edge;
	////////////////////////////////////////////////////////////////
	// Counters start clear and the done pin starts pulled low.
	initial begin
		o_bits = '0;
		o_tail = '0;
		o_viol = '0;
		pull_low = 1'b1;
		t_fall = 0.0;
		t_rel = 0.0;
		t_edge = 0.0;
	end
	// The external pull-up lifts the pin once the model lets go.
	assign o_done_pin = pull_low ? 1'b0 : 1'b1;
	// A reset pulse restarts the load and holds done low again.
	always @(negedge i_creset_n) begin
		t_fall = $realtime;
		pull_low = 1'b1;
		o_bits = '0;
		o_tail = '0;
	end
	// The first rise from an unknown level is not a real pulse, so it is skipped.
	always @(posedge i_creset_n) begin
		t_rel = $realtime;
		if (t_fall > 0.0 && t_rel - t_fall < 320.0) o_viol = o_viol + 8'h01;
	end
	// Each clock phase must last at least 4.8 ns.
	always @(i_config_serial_clock) begin
		if (t_edge > 0.0 && $realtime - t_edge < 4.8) o_viol = o_viol + 8'h01;
		t_edge = $realtime;
	end
	// Data is taken on the rising edge only while both selects are held.
	always @(posedge i_config_serial_clock) begin
		if (i_ssel_n === 1'b0 && i_csel === 1'b1 && i_creset_n === 1'b1) begin
			if (o_bits < (i_expect_bytes << 3)) begin
				if (o_bits == 16'h0 && $realtime - t_rel < FIRST_NS) o_viol = o_viol + 8'h01;
				sh = {sh[6:0], i_config_serial_data_in};
				if (o_bits[2:0] == 3'h7) mem[o_bits[7:3]] = sh;
				o_bits = o_bits + 16'h1;
			end else begin
				o_tail = o_tail + 16'h1;
				if (o_tail >= 16'd100 && !i_hold_done) pull_low = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the passive serial configuration host.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int HOLD = 10;
	logic clk, rst_n, start, last, busy, done, error, user_rst_n;
	logic bvalid, bready, ser_clk, ser_data, ssel_n, csel, creset_n, done_pin, hold, prev_cr;
	logic [7:0] bdata;
	logic [7:0] viol;
	logic [15:0] expect_b, bits, tail;
	int err_count, num_checks, cyc, sel_bad, rst_low, rst_falls, hold_cyc;
	////////////////////////////////////////////////////////////////
	cfgh_host #(.CLK_DIV(4), .FIRST_DATA_CYC(20), .USER_HOLD_CYC(HOLD), .DONE_TIMEOUT(500)) dut_u (
		.i_clk_sys(clk), .i_reset_n(rst_n), .i_start(start), .i_last(last), .o_busy(busy),
		.o_done(done), .o_error(error), .o_user_reset_n(user_rst_n), .i_byte_valid(bvalid),
		.i_byte_data(bdata), .o_byte_ready(bready), .o_config_serial_clock(ser_clk),
		.o_config_serial_data_in(ser_data), .o_flash_slave_select_n(ssel_n), .o_config_select(csel),
		.o_config_reset_n(creset_n), .i_config_complete_flag(done_pin));
	cfgh_dev_model #(.FIRST_NS(200)) model_u (
		.i_config_serial_clock(ser_clk), .i_config_serial_data_in(ser_data), .i_ssel_n(ssel_n),
		.i_csel(csel), .i_creset_n(creset_n),
		.i_expect_bytes(expect_b), .i_hold_done(hold), .o_done_pin(done_pin), .o_bits(bits),
		.o_tail(tail), .o_viol(viol));
	// Free-running system clock.
	always #5 clk = ~clk;
	// Pin watch each cycle; a hang is cut short by the cycle ceiling.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		prev_cr <= creset_n;
		if (busy === 1'b1 && user_rst_n === 1'b0 && (csel !== 1'b1 || ssel_n !== 1'b0)) sel_bad <= sel_bad + 1;
		if (rst_n === 1'b1 && busy === 1'b0 && ser_clk !== 1'b1) sel_bad <= sel_bad + 1;
		if (creset_n === 1'b0) rst_low <= rst_low + 1;
		if (creset_n === 1'b0 && prev_cr === 1'b1) rst_falls <= rst_falls + 1;
		if (done_pin === 1'b1 && done !== 1'b1) hold_cyc <= hold_cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end
	// Counts a comparison and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bitstream byte pattern, distinct per position.
	function automatic logic [7:0] pat(input int i);
		return 8'h5a ^ 8'(i * 37);
	endfunction
	// Holds the design in reset for 20 cycles and checks the idle pin levels.
	task automatic t_reset();
		rst_n = 1'b0;
		repeat (20) @(negedge clk);
		chk({ser_clk, ser_data, ssel_n, csel, creset_n, busy, done, error, user_rst_n}, 9'h1d0);
		rst_n = 1'b1;
		@(negedge clk);
	endtask
	// One whole load; a gap starves the feed, hd keeps the done pin low.
	task automatic run_load(input int n, input int gap, input logic hd);
		int k;
		expect_b = 16'(n);
		hold = hd;
		rst_low = 0;
		rst_falls = 0;
		sel_bad = 0;
		hold_cyc = 0;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (int i = 0; i < n; i++) begin
			bdata = pat(i);
			bvalid = 1'b1;
			k = 0;
			while (bready !== 1'b1 && k < 2000) begin
				@(negedge clk);
				k++;
			end
			@(negedge clk);
			if (i == 15) chk({31'h0, bready}, 0);
			if (gap > 0) begin
				bvalid = 1'b0;
				repeat (gap) @(negedge clk);
			end
		end
		bvalid = 1'b0;
		last = 1'b1;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		k = 0;
		while (busy !== 1'b0 && k < 8000) begin
			@(negedge clk);
			k++;
		end
		last = 1'b0;
		chk(rst_low, 32);
		chk(rst_falls, 1);
		chk(sel_bad, 0);
		chk({24'h0, viol}, 0);
		chk({16'h0, bits}, n * 8);
		for (int i = 0; i < n; i++) chk({24'h0, model_u.mem[i]}, {24'h0, pat(i)});
		chk({31'h0, tail >= 16'd100}, 1);
		chk({30'h0, done, error}, hd ? 1 : 2);
		if (!hd) chk({31'h0, hold_cyc >= HOLD && user_rst_n === 1'b1}, 1);
	endtask
	// Short load with no stalls.
	task automatic t_plain();
		run_load(3, 0, 1'b0);
	endtask
	// Feed fills the buffer until it refuses.
	task automatic t_full();
		run_load(20, 0, 1'b0);
	endtask
	// Feed pauses 40 cycles between bytes; the bytes buffered during reset and wait keep the clock from stopping.
	task automatic t_stall();
		run_load(4, 40, 1'b0);
	endtask
	// Done never rises, so the load ends in error.
	task automatic t_nodone();
		run_load(2, 0, 1'b1);
	endtask
	// Prints the verdict and ends the run.
	task automatic finish_test();
		if (err_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		clk = 1'b0;
		start = 1'b0;
		last = 1'b0;
		bvalid = 1'b0;
		bdata = 8'h00;
		expect_b = 16'h0;
		hold = 1'b0;
		err_count = 0;
		num_checks = 0;
		cyc = 0;
		t_reset();
		t_plain();
		t_full();
		t_stall();
		t_nodone();
		finish_test();
	end
endmodule
`default_nettype wire
